// [pkg/strap_pkg.sv]
// constants and carrier types for the strap latch and rmii receive block
package strap_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_STRAP  = 8'h00;
	localparam logic [7:0] OFS_CTRL   = 8'h04;
	localparam logic [7:0] OFS_FRAMES = 8'h08;
	localparam logic [7:0] OFS_PHYREG = 8'h0C;
	// control register fields
	localparam int CTRL_RX_EN  = 0;
	localparam int CTRL_CLK50  = 1;
	localparam int CTRL_LED0   = 2;
	localparam int CTRL_ADDR0  = 3;
	localparam int CTRL_ADDR1  = 4;
	localparam int CTRL_INTR   = 5;
	localparam int CTRL_REFPIN = 6;
	localparam logic [31:0] CTRL_MASK  = 32'h0000_007F;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// management register 0 field positions
	localparam int REG0_AUTONEG_BIT = 12;
	localparam int REG0_DUPLEX_BIT  = 8;
	// axi answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// management frame layout
	localparam logic [5:0] MD_PRE_BITS  = 6'h20;
	localparam logic [5:0] MD_HDR_LAST  = 6'h0D;
	localparam logic [5:0] MD_DATA_LAST = 6'h0F;
	localparam logic [1:0] MD_START     = 2'h1;
	localparam logic [1:0] MD_OP_RD     = 2'h2;
	localparam logic [1:0] MD_OP_WR     = 2'h1;

	typedef enum logic [1:0] {
		MD_PRE  = 2'h0,
		MD_HDR  = 2'h1,
		MD_TA   = 2'h3,
		MD_DATA = 2'h2
	} mdio_state_type;

	// latched strap values, bit 6 first
	typedef struct packed {
		logic       duplex;
		logic [2:0] addr;
		logic       chain_test_en;
		logic       bcast_dis;
		logic       autoneg;
	} strap_type;
	// auto-neg on, addr 1, half duplex level high
	localparam strap_type STRAP_RESET = 7'h49;

	// multiplexed strap pins
	typedef struct packed {
		logic crs_dv;
		logic rxd0;
		logic rxd1;
		logic addr1;
		logic addr0;
		logic intr;
		logic ref_pin;
		logic led0;
	} pins_type;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;
endpackage

// [rtl/mdio_slave.sv]
`timescale 1ns/1ns
// management data slave paced by sampled mdc rising edges
module mdio_slave (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        mdc_rise,
	input  wire logic        mdio_bit,
	input  wire logic [4:0]  own_addr,
	input  wire logic        bcast_disable,
	input  wire logic [15:0] reg0_value,
	output logic             mdio_oe
);
	strap_pkg::mdio_state_type state_q, state_d;
	logic [5:0]  cnt_q, cnt_d;
	logic [13:0] hdr_q, hdr_d;
	logic [15:0] sh_q, sh_d;
	logic        rd_q, rd_d;
	logic        oe_q, oe_d;
	logic [13:0] hdr_next;
	logic        hit;

	assign hdr_next = {hdr_q[12:0], mdio_bit};
	assign hit = (hdr_next[9:5] == own_addr) || (hdr_next[9:5] == 5'h00 && !bcast_disable);
	assign mdio_oe = oe_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		hdr_d = hdr_q;
		sh_d = sh_q;
		rd_d = rd_q;
		oe_d = oe_q;
		if (mdc_rise) begin
			case (state_q)
			strap_pkg::MD_PRE: begin
				if (mdio_bit) begin
					if (cnt_q != strap_pkg::MD_PRE_BITS)
						cnt_d = cnt_q + 6'h01;
				end else if (cnt_q == strap_pkg::MD_PRE_BITS) begin
					state_d = strap_pkg::MD_HDR;
					hdr_d = 14'h0000;
					cnt_d = 6'h01;
				end else begin
					cnt_d = 6'h00;
				end
			end
			strap_pkg::MD_HDR: begin
				hdr_d = hdr_next;
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == strap_pkg::MD_HDR_LAST) begin
					cnt_d = 6'h00;
					state_d = strap_pkg::MD_PRE;
					if (hdr_next[13:12] == strap_pkg::MD_START && hit &&
						(hdr_next[11:10] == strap_pkg::MD_OP_RD || hdr_next[11:10] == strap_pkg::MD_OP_WR)) begin
						state_d = strap_pkg::MD_TA;
						rd_d = hdr_next[11:10] == strap_pkg::MD_OP_RD;
						sh_d = (hdr_next[4:0] == 5'h00) ? reg0_value : 16'h0000;
					end
				end
			end
			strap_pkg::MD_TA: begin
				if (cnt_q == 6'h00) begin
					oe_d = rd_q;
					cnt_d = 6'h01;
				end else begin
					oe_d = rd_q & ~sh_q[15];
					sh_d = {sh_q[14:0], 1'b0};
					cnt_d = 6'h00;
					state_d = strap_pkg::MD_DATA;
				end
			end
			strap_pkg::MD_DATA: begin
				if (cnt_q == strap_pkg::MD_DATA_LAST) begin
					oe_d = 1'b0;
					cnt_d = 6'h00;
					state_d = strap_pkg::MD_PRE;
				end else begin
					oe_d = rd_q & ~sh_q[15];
					sh_d = {sh_q[14:0], 1'b0};
					cnt_d = cnt_q + 6'h01;
				end
			end
			default: begin
				state_d = strap_pkg::MD_PRE;
				cnt_d = 6'h00;
				oe_d = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= strap_pkg::MD_PRE;
			cnt_q <= 6'h00;
			hdr_q <= 14'h0000;
			sh_q <= 16'h0000;
			rd_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			hdr_q <= hdr_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			oe_q <= oe_d;
		end
	end
endmodule

// [rtl/strap_config_latch.sv]
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
// strap latch, rmii receive pins, management slave and axi-lite registers
// How it works
// - auto-neg strap latched into register 0 bit 12
// - broadcast-disable strap makes address zero unique
// - chain-test strap low enables test mode
// - three address straps latched, bit two on rxd1
// - rxd0 level latched as duplex strap
// - strap pins input in reset, outputs after, except intr until its ctrl bit is set and ref pin in 50 MHz mode
// - two data bits per reference clock while valid
// - management data timed by incoming mdc clock
// - management data open-drain, only pulled low
// - selectable 25 or 50 MHz clock input mode
// - carrier/valid output on the config strap pin
module strap_config_latch (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ref_clk,
	input  wire strap_pkg::axi_req_type axi_req,
	output strap_pkg::axi_rsp_type      axi_rsp,
	input  wire strap_pkg::pins_type   pin_in,
	output strap_pkg::pins_type         pin_out,
	output strap_pkg::pins_type         pin_oe,
	input  wire logic                  mdc_pin,
	input  wire logic                  mdio_in,
	output logic                        mdio_out,
	output logic                        mdio_oe,
	input  wire logic                  rec_valid,
	input  wire logic [1:0]            rec_dibit
);
	// pin and management synchronisers, free running
	strap_pkg::pins_type pin_s1_q, pin_s2_q;
	logic [1:0]  md_s1_q, md_s2_q;
	logic        mdc_last_q;
	logic        mdc_rise;
	logic        rst_hist_q;
	strap_pkg::strap_type strap_q, strap_d;
	logic [15:0] reg0_value;
	// axi slave state
	logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0]  waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic [31:0] ctrl_q, ctrl_d;
	// aclk pin drivers
	logic [4:0]  po_q, po_d, poe_q, poe_d;
	// frame counter fed from the link domain
	logic        frame_s1_q, frame_s2_q, frame_s3_q;
	logic [31:0] frame_cnt_q, frame_cnt_d;
	// link domain
	logic        ref_rst_s1_q, ref_rst_s2_q;
	logic        ref_en_s1_q, ref_en_s2_q;
	logic        crs_q, crs_d;
	logic [1:0]  rxd_q, rxd_d;
	logic        ref_oe_q;
	logic        frame_tgl_q, frame_tgl_d;

	function automatic logic mapped(input logic [7:0] addr);
		mapped = addr == strap_pkg::OFS_STRAP || addr == strap_pkg::OFS_CTRL ||
			addr == strap_pkg::OFS_FRAMES || addr == strap_pkg::OFS_PHYREG;
	endfunction

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = wd[i*8 +: 8];
		end
		merge_bytes = res;
	endfunction

	always_ff @(posedge aclk) begin
		pin_s1_q <= pin_in;
		pin_s2_q <= pin_s1_q;
		md_s1_q <= {mdio_in, mdc_pin};
		md_s2_q <= md_s1_q;
		mdc_last_q <= md_s2_q[0];
		frame_s1_q <= frame_tgl_q;
		frame_s2_q <= frame_s1_q;
		frame_s3_q <= frame_s2_q;
	end
	assign mdc_rise = md_s2_q[0] & ~mdc_last_q;

	// marks the first edge after reset release
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rst_hist_q <= 1'b1;
		else
			rst_hist_q <= 1'b0;
	end

	always_comb begin
		strap_d = strap_q;
		if (rst_hist_q) begin
			strap_d.autoneg = pin_s2_q.led0;
			strap_d.bcast_dis = pin_s2_q.ref_pin;
			strap_d.chain_test_en = ~pin_s2_q.intr;
			strap_d.addr = {pin_s2_q.rxd1, pin_s2_q.addr1, pin_s2_q.addr0};
			strap_d.duplex = pin_s2_q.rxd0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			strap_q <= strap_pkg::STRAP_RESET;
		else
			strap_q <= strap_d;
	end

	// pull-up level means half duplex, so bit 8 is inverted
	always_comb begin
		reg0_value = 16'h0000;
		reg0_value[strap_pkg::REG0_AUTONEG_BIT] = strap_q.autoneg;
		reg0_value[strap_pkg::REG0_DUPLEX_BIT] = ~strap_q.duplex;
	end

	always_comb begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ctrl_d = ctrl_q;
		if (axi_req.awvalid && awready_q) begin
			aw_held_d = 1'b1;
			waddr_d = axi_req.awaddr;
		end
		if (axi_req.wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d = axi_req.wdata;
			wstrb_d = axi_req.wstrb;
		end
		if (bvalid_q && axi_req.bready)
			bvalid_d = 1'b0;
		if (aw_held_q && w_held_q && !bvalid_q) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(waddr_q) ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
			if (waddr_q == strap_pkg::OFS_CTRL)
				ctrl_d = merge_bytes(ctrl_q, wdata_q, wstrb_q) & strap_pkg::CTRL_MASK;
		end
		awready_d = !aw_held_d && !bvalid_d;
		wready_d = !w_held_d && !bvalid_d;
	end

	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && axi_req.rready)
			rvalid_d = 1'b0;
		if (axi_req.arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d = mapped(axi_req.araddr) ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
			case (axi_req.araddr)
			strap_pkg::OFS_STRAP: rdata_d = 32'({ctrl_q[strap_pkg::CTRL_CLK50], strap_q});
			strap_pkg::OFS_CTRL: rdata_d = ctrl_q;
			strap_pkg::OFS_FRAMES: rdata_d = frame_cnt_q;
			strap_pkg::OFS_PHYREG: rdata_d = 32'(reg0_value);
			default: rdata_d = 32'h0000_0000;
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			waddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= strap_pkg::RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= strap_pkg::RESP_OKAY;
			ctrl_q <= strap_pkg::CTRL_RESET;
		end else begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			ctrl_q <= ctrl_d;
		end
	end

	assign axi_rsp = {awready_q, wready_q, bvalid_q, bresp_q, arready_q, rvalid_q, rdata_q, rresp_q};

	// pin order: addr1, addr0, intr, ref_pin, led0
	always_comb begin
		po_d = {ctrl_q[strap_pkg::CTRL_ADDR1], ctrl_q[strap_pkg::CTRL_ADDR0], 1'b0,
			ctrl_q[strap_pkg::CTRL_REFPIN], ctrl_q[strap_pkg::CTRL_LED0]};
		// ref pin floats in 50 MHz mode
		poe_d = {2'h3, ctrl_q[strap_pkg::CTRL_INTR], ~ctrl_q[strap_pkg::CTRL_CLK50], 1'b1};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			po_q <= 5'h00;
			poe_q <= 5'h00;
		end else begin
			po_q <= po_d;
			poe_q <= poe_d;
		end
	end

	always_comb begin
		frame_cnt_d = frame_cnt_q;
		if (frame_s2_q ^ frame_s3_q)
			frame_cnt_d = frame_cnt_q + 32'h0000_0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			frame_cnt_q <= 32'h0000_0000;
		else
			frame_cnt_q <= frame_cnt_d;
	end

	mdio_slave u_mdio (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.mdc_rise      (mdc_rise),
		.mdio_bit      (md_s2_q[1]),
		.own_addr      ({2'h0, strap_q.addr}),
		.bcast_disable (strap_q.bcast_dis),
		.reg0_value    (reg0_value),
		.mdio_oe       (mdio_oe)
	);
	assign mdio_out = 1'b0;

	// link domain: reset and enable cross as levels
	always_ff @(posedge ref_clk) begin
		ref_rst_s1_q <= aresetn;
		ref_rst_s2_q <= ref_rst_s1_q;
		ref_en_s1_q <= ctrl_q[strap_pkg::CTRL_RX_EN];
		ref_en_s2_q <= ref_en_s1_q;
	end

	always_comb begin
		crs_d = rec_valid & ref_en_s2_q;
		rxd_d = crs_d ? rec_dibit : 2'h0;
		// end of frame flips the toggle seen by aclk
		frame_tgl_d = frame_tgl_q ^ (crs_q & ~crs_d);
	end

	// link pins released until reset has crossed
	always_ff @(posedge ref_clk) begin
		if (!ref_rst_s2_q) begin
			crs_q <= 1'b0;
			rxd_q <= 2'h0;
			ref_oe_q <= 1'b0;
			frame_tgl_q <= 1'b0;
		end else begin
			crs_q <= crs_d;
			rxd_q <= rxd_d;
			ref_oe_q <= 1'b1;
			frame_tgl_q <= frame_tgl_d;
		end
	end

	assign pin_out = {crs_q, rxd_q[0], rxd_q[1], po_q};
	assign pin_oe = {ref_oe_q, ref_oe_q, ref_oe_q, poe_q};
endmodule

// [sim/strap_config_latch_monitor.sv]
// concurrent checks on strap pins, rmii receive pins and mdio
`timescale 1ns/1ns
module strap_config_latch_monitor (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   ref_clk,
	input wire strap_pkg::axi_rsp_type axi_rsp,
	input wire strap_pkg::pins_type    pin_out,
	input wire strap_pkg::pins_type    pin_oe,
	input wire logic                   mdc_pin,
	input wire logic                   mdio_out,
	input wire logic                   mdio_oe,
	input wire logic                   rec_valid,
	input wire logic [1:0]             rec_dibit
);
	a_reset_oe_low: assert property (@(posedge aclk) !aresetn |=> pin_oe[4:0] == 5'h00)
		else $error("strap pin driven in reset");
	a_oe_after_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn) |-> pin_oe.led0 && pin_oe.addr0 && pin_oe.addr1)
		else $error("strap pin not driven after reset");
	a_mdio_open_drain: assert property (@(posedge aclk) disable iff (!aresetn) mdio_out == 1'b0)
		else $error("mdio driven high");
	// detection of a rise lags mdc by two or three cycles
	a_mdio_on_mdc: assert property (@(posedge aclk) disable iff (!aresetn)
		$changed(mdio_oe) |-> $past(mdc_pin, 2))
		else $error("mdio changed away from mdc rise");
	a_rx_follow: assert property (@(posedge ref_clk) disable iff (!aresetn)
		pin_out.crs_dv |-> $past(rec_valid) && {pin_out.rxd1, pin_out.rxd0} == $past(rec_dibit))
		else $error("receive bits do not follow input");
	a_rx_gap: assert property (@(posedge ref_clk) disable iff (!aresetn) !rec_valid |=> !pin_out.crs_dv)
		else $error("valid without input");
	a_rx_idle_zero: assert property (@(posedge ref_clk) disable iff (!aresetn)
		!pin_out.crs_dv |-> {pin_out.rxd1, pin_out.rxd0} == 2'b00)
		else $error("receive bits outside valid");
	a_crs_driven: assert property (@(posedge ref_clk) disable iff (!aresetn) pin_out.crs_dv |-> pin_oe.crs_dv)
		else $error("valid pin not driven");
	c_rx: cover property (@(posedge ref_clk) pin_out.crs_dv);
	c_mdio: cover property (@(posedge aclk) $rose(mdio_oe));
	c_err: cover property (@(posedge aclk) axi_rsp.bvalid && axi_rsp.bresp == strap_pkg::RESP_SLVERR);
endmodule
bind strap_config_latch strap_config_latch_monitor strap_config_latch_monitor_inst (.aclk(aclk),
	.aresetn(aresetn), .ref_clk(ref_clk), .axi_rsp(axi_rsp), .pin_out(pin_out), .pin_oe(pin_oe),
	.mdc_pin(mdc_pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rec_valid(rec_valid), .rec_dibit(rec_dibit));

// [sim/mac_partner.sv]
// mac side: management master and rmii receive capture
`timescale 1ns/1ns
module mac_partner (
	input  wire logic       ref_clk,
	input  wire logic       crs_dv,
	input  wire logic [1:0] rxd,
	input  wire logic       mdio_lvl,
	input  wire logic       start,
	input  wire logic       wr,
	input  wire logic [4:0] phy,
	output logic            mdc,
	output logic            mdio_low,
	output logic            done,
	output logic [15:0]     rd,
	output logic [7:0]      rx_q,
	output logic [7:0]      rx_n
);
	logic [63:0] frame;
	initial begin
		mdc = 0;
		mdio_low = 0;
		done = 1;
		rx_q = '0;
		rx_n = '0;
	end
	// first dibit lands in the low bits
	always @(posedge ref_clk)
		if (crs_dv) begin
			rx_q <= {rxd, rx_q[7:2]};
			rx_n <= rx_n + 8'h01;
		end
	// change while mdc low, sample at rise, only pull low
	always @(posedge start) begin
		done = 0;
		// write frames drive turnaround 10 and all-ones data, so any pull by the phy shows up
		frame = {32'hFFFF_FFFF, wr ? 4'h5 : 4'h6, phy, 5'h00, wr ? 2'b10 : 2'b11, 16'hFFFF};
		// keep mdc and data edges off the aclk edges
		#5;
		for (int i = 63; i >= 0; i--) begin
			mdio_low = !frame[i];
			#100;
			mdc = 1;
			if (i < 16)
				rd = {rd[14:0], mdio_lvl};
			#100;
			mdc = 0;
		end
		mdio_low = 0;
		done = 1;
	end
endmodule

// [sim/strap_config_latch_tb.sv]
// self-checking bench for the strap latch block
`timescale 1ns/1ns
module strap_config_latch_tb;
	logic                   aclk = 0;
	logic                   aresetn = 0;
	logic                   ref_clk = 0;
	strap_pkg::axi_req_type req = '0;
	strap_pkg::axi_rsp_type rsp;
	strap_pkg::pins_type    pins = '0;
	strap_pkg::pins_type    pout;
	strap_pkg::pins_type    poe;
	logic                   mdc, mdio_out, mdio_oe, mac_low, done;
	logic                   start = 0;
	logic                   wr = 0;
	logic                   rec_valid = 0;
	logic [1:0]             rec_dibit = 0;
	logic [4:0]             phy = 0;
	logic [15:0]            rd;
	logic [7:0]             rx_q, rx_n, p;
	logic [31:0]            v, f0, e;
	logic [1:0]             r;
	int                     errors = 0;
	int                     n_checks = 0;
	wire                    mdio_lvl = !((mdio_oe && !mdio_out) || mac_low);

	always #10 aclk = ~aclk;
	always #80 ref_clk = ~ref_clk;

	strap_config_latch strap_config_latch_inst (.aclk(aclk), .aresetn(aresetn), .ref_clk(ref_clk), .axi_req(req),
		.axi_rsp(rsp), .pin_in(pins), .pin_out(pout), .pin_oe(poe), .mdc_pin(mdc), .mdio_in(mdio_lvl),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .rec_valid(rec_valid), .rec_dibit(rec_dibit));
	mac_partner mac_partner_inst (.ref_clk(ref_clk), .crs_dv(pout.crs_dv), .rxd({pout.rxd1, pout.rxd0}),
		.mdio_lvl(mdio_lvl), .start(start), .wr(wr), .phy(phy), .mdc(mdc), .mdio_low(mac_low), .done(done),
		.rd(rd), .rx_q(rx_q), .rx_n(rx_n));

	task automatic give_verdict;
		$display("errors %0d checks %0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bound(input bit bad);
		if (bad) begin
			errors++;
			give_verdict;
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		req.awaddr <= a;
		req.awvalid <= 1;
		req.wdata <= d;
		req.wstrb <= 4'hF;
		req.wvalid <= 1;
		req.bready <= 1;
		for (n = 0; n < 60 && (req.awvalid || req.wvalid || !rsp.bvalid); n++) begin
			@(posedge aclk);
			if (rsp.awready)
				req.awvalid <= 0;
			if (rsp.wready)
				req.wvalid <= 0;
		end
		bound(n >= 60);
		r = rsp.bresp;
		req.bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1;
		req.rready <= 1;
		for (n = 0; n < 60 && !rsp.rvalid; n++) begin
			@(posedge aclk);
			if (rsp.arready)
				req.arvalid <= 0;
		end
		bound(n >= 60);
		v = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 0;
	endtask
	task automatic mdio_xfer(input logic [4:0] a, input logic w);
		int n;
		@(posedge aclk);
		phy <= a;
		wr <= w;
		start <= 1;
		@(posedge aclk);
		start <= 0;
		for (n = 0; n < 800 && !done; n++)
			@(posedge aclk);
		bound(n >= 800);
	endtask
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			rec_valid <= 1;
			rec_dibit <= b[2*i +: 2];
		end
		@(posedge ref_clk);
		rec_valid <= 0;
		rec_dibit <= 2'b00;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		for (int k = 0; k < 2; k++) begin
			p = k ? 8'h55 : 8'h2A;
			@(posedge aclk);
			aresetn <= 0;
			pins <= p;
			repeat (20) @(posedge aclk);
			check("oe in reset", {24'h0, poe & 8'h1F}, 32'h0);
			aresetn <= 1;
			repeat (30) @(posedge aclk);
			check("oe after reset", {24'h0, poe}, 32'hFB);
			e = {25'h0, p[6:3], ~p[2], p[1:0]};
			axi_rd(strap_pkg::OFS_STRAP);
			check("strap", v, e);
			pins <= ~p;
			axi_rd(strap_pkg::OFS_STRAP);
			check("strap held", v, e);
			e = {19'h0, p[0], 3'h0, ~p[6], 8'h0};
			axi_rd(strap_pkg::OFS_PHYREG);
			check("reg0", v, e);
			mdio_xfer({2'b00, p[5:3]}, 1'b0);
			check("mdio own addr", {16'h0, rd}, e);
			mdio_xfer(5'h00, 1'b0);
			check("mdio addr zero", {16'h0, rd}, p[1] ? 32'hFFFF : e);
			mdio_xfer({2'b00, p[5:3]}, 1'b1);
			check("mdio write quiet", {16'h0, rd}, 32'h0000_FFFF);
			mdio_xfer({2'b00, p[5:3]}, 1'b0);
			check("mdio after write", {16'h0, rd}, e);
		end
		axi_rd(strap_pkg::OFS_FRAMES);
		f0 = v;
		send(8'hB4);
		repeat (10) @(posedge aclk);
		check("rx byte", {24'h0, rx_q}, 32'hB4);
		axi_rd(strap_pkg::OFS_FRAMES);
		check("frames", v, f0 + 32'h1);
		axi_wr(strap_pkg::OFS_CTRL, 32'hFFFF_FFFE);
		check("ctrl resp", {30'h0, r}, {30'h0, strap_pkg::RESP_OKAY});
		axi_rd(strap_pkg::OFS_CTRL);
		check("ctrl", v, 32'h7E);
		check("pins out", {24'h0, pout & 8'h1F}, 32'h1B);
		check("pins oe", {24'h0, poe & 8'h1F}, 32'h1D);
		f0 = {24'h0, rx_n};
		repeat (5) @(posedge ref_clk);
		send(8'h3C);
		check("rx blocked", {24'h0, rx_n}, f0);
		axi_rd(8'h10);
		check("bad read", {r, v[29:0]}, {strap_pkg::RESP_SLVERR, 30'h0});
		axi_wr(8'h10, 32'h0000_0001);
		check("bad write", {30'h0, r}, {30'h0, strap_pkg::RESP_SLVERR});
		give_verdict;
	end
endmodule
